/* File: rtl/qhs_serial_port.sv */
// Serial slave port, wake logic, fault flag and sense select of a quad switch
`timescale 1ns/1ps
module qhs_serial_port
(
    input  wire logic        sys_clk,          // System clock, 200 MHz
    input  wire logic        reset,            // Synchronous reset, active high
    input  wire logic        cs_n,             // Chip select pin, active low
    input  wire logic        sclk,             // Serial clock pin
    input  wire logic        sdi,              // Serial data in pin
    output logic             sdo_o,            // Serial data out value
    output logic             sdo_oe_n,         // Serial out enable, low drives
    input  wire logic        rst_pin_n,        // Device reset pin, active low
    input  wire logic        wake_pin,         // Wake pin, active high
    input  wire logic        direct_input_0,   // Direct input 0, PWM clock too
    input  wire logic        direct_input_1,   // Direct input 1
    input  wire logic        direct_input_2,   // Direct input 2
    input  wire logic        direct_input_3,   // Direct input 3
    input  wire logic [3:0]  fault_detect,     // Per-output fault conditions
    input  wire logic [3:0]  output_status,    // Per-output on/off state
    input  wire logic        pwm_mode,         // Outputs driven by PWM module
    input  wire logic [3:0]  pwm_outputs,      // PWM module output levels
    output logic [3:0]       switch_outputs,   // High side switch commands
    output logic             fault_flag_n_o,   // Fault flag output value
    output logic             fault_flag_n_oe_n,// Fault flag enable, low pulls
    output logic [2:0]       sense_sel,        // Sense source selection
    output logic             sense_hiz,        // Sense output floating
    output logic             awake,            // Device out of sleep
    output logic             watchdog_start,   // Pulse: start watchdog
    output logic             pwm_clk_in,       // External PWM clock level
    output logic             reg_wr,           // Pulse: register write
    output logic [4:0]       reg_addr,         // Written register address
    output logic [9:0]       reg_data          // Written register data
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic       cs_lvl;
    logic       cs_rise;
    logic       cs_fall;
    logic       sclk_rise;
    logic       sclk_fall;
    logic       sdi_lvl;
    logic       rstp_lvl;
    logic       rstp_rise;
    logic       wake_lvl;
    logic [3:0] din_lvl;
    logic [3:0] din_raw;

    assign din_raw = {direct_input_3, direct_input_2, direct_input_1, direct_input_0};

    qhs_sync u_cs_sync
    (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .async_in (cs_n),
        .rst_val  (1'b1),
        .level    (cs_lvl),
        .rise     (cs_rise),
        .fall     (cs_fall)
    );

    qhs_sync u_sclk_sync
    (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .async_in (sclk),
        .rst_val  (1'b0),
        .level    (),
        .rise     (sclk_rise),
        .fall     (sclk_fall)
    );

    qhs_sync u_sdi_sync
    (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .async_in (sdi),
        .rst_val  (1'b0),
        .level    (sdi_lvl),
        .rise     (),
        .fall     ()
    );

    qhs_sync u_rst_sync
    (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .async_in (rst_pin_n),
        .rst_val  (1'b0),
        .level    (rstp_lvl),
        .rise     (rstp_rise),
        .fall     ()
    );

    qhs_sync u_wake_sync
    (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .async_in (wake_pin),
        .rst_val  (1'b0),
        .level    (wake_lvl),
        .rise     (),
        .fall     ()
    );

    genvar gi;
    generate
        for (gi = 0; gi < qhs_pkg::NUM_OUT; gi++)
        begin : g_din
            qhs_sync u_din_sync
            (
                .sys_clk  (sys_clk),
                .reset    (reset),
                .async_in (din_raw[gi]),
                .rst_val  (1'b0),
                .level    (din_lvl[gi]),
                .rise     (),
                .fall     ()
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Frame control
    // ------------------------------------------------------------
    logic        selected;
    logic [15:0] status_word;
    logic [15:0] rx_word;
    logic [4:0]  rx_count;
    logic        sdo_bit;
    logic [3:0]  fault_latch_r;

    assign selected = ~cs_lvl & rstp_lvl;

    // Status word: fault flag, latched faults, output states, inputs
    assign status_word = {1'b0, |fault_latch_r, 2'b00, fault_latch_r,
                          output_status, din_lvl};

    qhs_shifter u_shifter
    (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .active    (selected),
        .load      (cs_fall),
        .load_word (status_word),
        .sclk_rise (sclk_rise),
        .sclk_fall (sclk_fall),
        .sdi       (sdi_lvl),
        .rx_word   (rx_word),
        .rx_count  (rx_count),
        .sdo       (sdo_bit)
    );

    // Frames of 16 or more bits commit, keeping the last 16 bits received; short frames are dropped
    function automatic logic [4:0] addr_of(input logic [15:0] w);
        addr_of = w[qhs_pkg::ADDR_MSB:qhs_pkg::ADDR_LSB];
    endfunction

    logic commit;
    assign commit = cs_rise & rstp_lvl & (rx_count == qhs_pkg::BITS_FULL);

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            reg_wr   <= 1'b0;
            reg_addr <= 5'h00;
            reg_data <= qhs_pkg::REG_RESET;
        end
        else
        begin
            reg_wr <= commit;
            if (commit)
            begin
                reg_addr <= addr_of(rx_word);
                reg_data <= rx_word[qhs_pkg::DATA_W-1:0];
            end
        end
    end

    // Output enable follows synchronised select; floats when deselected
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            sdo_oe_n <= 1'b1;
            sdo_o    <= 1'b0;
        end
        else
        begin
            sdo_oe_n <= ~selected;
            sdo_o    <= sdo_bit;
        end
    end

    // ------------------------------------------------------------
    // Local control registers
    // ------------------------------------------------------------
    logic [3:0] spi_out_r;
    logic [2:0] sense_sel_r;
    logic       sense_en_r;

    always_ff @(posedge sys_clk)
    begin
        if (reset || !rstp_lvl)
        begin
            spi_out_r   <= 4'h0;
            sense_sel_r <= 3'b000;
            sense_en_r  <= 1'b0;
        end
        else if (commit)
        begin
            case (addr_of(rx_word))
                qhs_pkg::ADDR_OUT_CTRL:
                    spi_out_r <= rx_word[qhs_pkg::NUM_OUT-1:0];
                qhs_pkg::ADDR_SENSE_CTRL:
                begin
                    sense_sel_r <= rx_word[qhs_pkg::SENSE_SEL_LSB +: 3];
                    sense_en_r  <= rx_word[qhs_pkg::SENSE_EN_BIT];
                end
                default:
                    spi_out_r <= spi_out_r;
            endcase
        end
    end

    assign sense_sel = sense_sel_r;
    assign sense_hiz = ~sense_en_r;

    // Faults latch until cleared by command; a new fault wins over the clear
    logic fault_clr;
    assign fault_clr = commit && (addr_of(rx_word) == qhs_pkg::ADDR_FAULT_CLR);

    always_ff @(posedge sys_clk)
    begin
        if (reset || !rstp_lvl)
            fault_latch_r <= 4'h0;
        else
            fault_latch_r <= fault_detect | (fault_clr ? 4'h0 : fault_latch_r);
    end

    // ------------------------------------------------------------
    // Wake and mode
    // ------------------------------------------------------------
    logic                 wake_any;
    qhs_pkg::qhs_mode_type mode_r;
    qhs_pkg::qhs_mode_type mode_nxt;

    assign wake_any = rstp_lvl | wake_lvl | (|din_lvl);

    always_comb
    begin
        case (mode_r)
            qhs_pkg::MODE_SLEEP:
                mode_nxt = wake_any ? qhs_pkg::MODE_NORMAL : qhs_pkg::MODE_SLEEP;
            qhs_pkg::MODE_NORMAL:
                mode_nxt = !wake_any ? qhs_pkg::MODE_SLEEP
                         : (|fault_detect) ? qhs_pkg::MODE_FAULT : qhs_pkg::MODE_NORMAL;
            qhs_pkg::MODE_FAULT:
                mode_nxt = !wake_any ? qhs_pkg::MODE_SLEEP
                         : (|fault_detect) ? qhs_pkg::MODE_FAULT : qhs_pkg::MODE_NORMAL;
            default:
                mode_nxt = qhs_pkg::MODE_SLEEP;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            mode_r <= qhs_pkg::MODE_SLEEP;
        else
            mode_r <= mode_nxt;
    end

    assign awake = (mode_r != qhs_pkg::MODE_SLEEP);

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            watchdog_start <= 1'b0;
        else
            watchdog_start <= rstp_rise;
    end

    // ------------------------------------------------------------
    // Outputs and fault flag
    // ------------------------------------------------------------
    // Faulted outputs are forced off; sleep turns everything off
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            switch_outputs <= 4'h0;
        else if (!awake)
            switch_outputs <= 4'h0;
        else if (pwm_mode)
            switch_outputs <= pwm_outputs & ~fault_detect;
        else
            switch_outputs <= (din_lvl | spi_out_r) & ~fault_detect;
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            pwm_clk_in <= 1'b0;
        else
            pwm_clk_in <= din_lvl[0];
    end

    // Open drain: value always low, enable pulls during any fault
    assign fault_flag_n_o = 1'b0;

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            fault_flag_n_oe_n <= 1'b1;
        else
            fault_flag_n_oe_n <= ~(|fault_detect);
    end

endmodule

/* File: inc/qhs_pkg.sv */
// Shared constants and types for the quad switch serial port and control pins
package qhs_pkg;

    // ------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------
    localparam int          WORD_W    = 16;
    localparam int          ADDR_W    = 5;
    localparam int          ADDR_MSB  = 14;
    localparam int          ADDR_LSB  = 10;
    localparam int          DATA_W    = 10;
    localparam int          NUM_REGS  = 32;
    localparam int          NUM_OUT   = 4;
    localparam int          BITCNT_W  = 5;
    localparam logic [4:0]  BITS_FULL = 5'h10;

    // ------------------------------------------------------------
    // Addressed register map (contents beyond this block are stubs)
    // ------------------------------------------------------------
    localparam logic [4:0]  ADDR_OUT_CTRL   = 5'h01;
    localparam logic [4:0]  ADDR_SENSE_CTRL = 5'h02;
    localparam logic [4:0]  ADDR_FAULT_CLR  = 5'h03;
    localparam logic [9:0]  REG_RESET       = 10'h000;

    // Sense control field positions
    localparam int          SENSE_SEL_LSB   = 0;
    localparam int          SENSE_EN_BIT    = 3;

    // ------------------------------------------------------------
    // Sense output selection
    // ------------------------------------------------------------
    typedef enum logic [2:0]
    {
        SENSE_OUT0 = 3'b000,
        SENSE_OUT1 = 3'b001,
        SENSE_OUT2 = 3'b010,
        SENSE_OUT3 = 3'b011,
        SENSE_TEMP = 3'b100
    } qhs_sense_type;

    // ------------------------------------------------------------
    // Power mode
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        MODE_SLEEP  = 2'b00,
        MODE_NORMAL = 2'b01,
        MODE_FAULT  = 2'b10
    } qhs_mode_type;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int          CLK_MHZ        = 200;
    localparam int          WAKE_HOLD_NS   = 100;
    localparam int          WAKE_HOLD_CYC  = (WAKE_HOLD_NS * CLK_MHZ) / 1000;
    localparam int          WAKE_CNT_W     = 5;

endpackage

/* File: rtl/qhs_sync.sv */
// Two-flop synchroniser with edge detection on the synchronised level
`timescale 1ns/1ps
module qhs_sync
(
    input  wire logic sys_clk,   // System clock
    input  wire logic reset,     // Synchronous reset, active high
    input  wire logic async_in,  // Level from outside the clock domain
    input  wire logic rst_val,   // Level assumed during reset
    output logic      level,     // Synchronised level
    output logic      rise,      // One-cycle pulse on rising edge
    output logic      fall       // One-cycle pulse on falling edge
);

    logic meta_r;
    logic sync_r;
    logic prev_r;

    // First stage feeds only the second stage
    always_ff @(posedge sys_clk)
    begin
        meta_r <= async_in;
        sync_r <= meta_r;
    end

    always_ff @(posedge sys_clk)
    begin
        // Idle level on reset, so release shows no false edge
        if (reset)
            prev_r <= rst_val;
        else
            prev_r <= sync_r;
    end

    assign level = sync_r;
    assign rise  = ~reset & sync_r & ~prev_r;
    assign fall  = ~reset & ~sync_r & prev_r;

endmodule

/* File: rtl/qhs_shifter.sv */
// Serial shift engine: samples input on clock fall, shifts output on clock rise
`timescale 1ns/1ps
module qhs_shifter
(
    input  wire logic        sys_clk,    // System clock
    input  wire logic        reset,      // Synchronous reset, active high
    input  wire logic        active,     // Chip select asserted (synchronised)
    input  wire logic        load,       // Load status word at frame start
    input  wire logic [15:0] load_word,  // Status word to send
    input  wire logic        sclk_rise,  // Serial clock rising edge
    input  wire logic        sclk_fall,  // Serial clock falling edge
    input  wire logic        sdi,        // Synchronised serial input
    output logic [15:0]      rx_word,    // Received word
    output logic [4:0]       rx_count,   // Bits received this frame
    output logic             sdo         // Current output bit
);

    logic [15:0] tx_r;
    logic [15:0] rx_r;
    logic [4:0]  cnt_r;
    logic        sdo_r;

    // Input sampled on falling serial clock, MSB first
    always_ff @(posedge sys_clk)
    begin
        if (reset || load)
        begin
            rx_r  <= 16'h0000;
            cnt_r <= 5'h00;
        end
        else if (active && sclk_fall)
        begin
            rx_r <= {rx_r[14:0], sdi};
            if (cnt_r != qhs_pkg::BITS_FULL)
                cnt_r <= cnt_r + 5'h01;
        end
    end

    // Output advances on rising serial clock; first bit shows at load
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            tx_r  <= 16'h0000;
            sdo_r <= 1'b0;
        end
        else if (load)
        begin
            tx_r  <= {load_word[14:0], 1'b0};
            sdo_r <= load_word[15];
        end
        else if (active && sclk_rise && cnt_r != 5'h00)
        begin
            sdo_r <= tx_r[15];
            tx_r  <= {tx_r[14:0], 1'b0};
        end
    end

    assign rx_word  = rx_r;
    assign rx_count = cnt_r;
    assign sdo      = sdo_r;

endmodule

/* File: tb/qhs_serial_port_assertions.sv */
// Pin-level checks for the quad switch serial port
`timescale 1ns/1ps
module qhs_serial_port_assertions
(
    input wire logic       sys_clk,           // Clock
    input wire logic       reset,             // Sync reset
    input wire logic       cs_n,              // Chip select
    input wire logic       rst_pin_n,         // Reset pin
    input wire logic       wake_pin,          // Wake pin
    input wire logic       direct_input_0,    // Input 0
    input wire logic       direct_input_1,    // Input 1
    input wire logic       direct_input_2,    // Input 2
    input wire logic       direct_input_3,    // Input 3
    input wire logic [3:0] fault_detect,      // Faults
    input wire logic       sdo_oe_n,          // Out enable
    input wire logic       fault_flag_n_o,    // Flag value
    input wire logic       fault_flag_n_oe_n, // Flag enable
    input wire logic [3:0] switch_outputs,    // Switches
    input wire logic       awake,             // Awake
    input wire logic       watchdog_start,    // Watchdog pulse
    input wire logic       reg_wr             // Write pulse
);
    logic wake_any;

    assign wake_any = rst_pin_n | wake_pin | direct_input_0 | direct_input_1
                      | direct_input_2 | direct_input_3;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    // ------
    // Serial port
    // ------
    a_so_released: assert property (cs_n [*6] |-> sdo_oe_n)
        else $error("serial out driven while deselected");
    a_so_driven: assert property ($fell(cs_n) ##1 (!cs_n && rst_pin_n) [*6] |-> !sdo_oe_n)
        else $error("serial out not driven in frame");
    a_wr_deselected: assert property (reg_wr |-> cs_n && $past(cs_n, 2))
        else $error("write before select released");
    a_wr_single: assert property (reg_wr |=> !reg_wr)
        else $error("write pulse too long");

    // ------
    // Pins
    // ------
    a_flag_follows: assert property (1'b1 |=> fault_flag_n_oe_n == ($past(fault_detect) == 4'h0))
        else $error("fault flag does not follow faults");
    a_flag_low: assert property (!fault_flag_n_oe_n |-> !fault_flag_n_o && $past(fault_detect) != 4'h0)
        else $error("fault flag not pulled low");
    a_wake_any: assert property (wake_any [*6] |-> awake)
        else $error("wake source ignored");
    a_sleep_off: assert property (!awake [*2] |-> switch_outputs == 4'h0)
        else $error("switch on while asleep");
    a_wdog_start: assert property ($rose(rst_pin_n) |-> ##[2:6] watchdog_start)
        else $error("watchdog not started");
    a_wdog_pulse: assert property (watchdog_start |=> !watchdog_start)
        else $error("watchdog pulse too long");

    cover property (reg_wr);
    cover property (watchdog_start);
    cover property (!fault_flag_n_oe_n);
endmodule

bind qhs_serial_port qhs_serial_port_assertions u_checker
(
    .sys_clk, .reset, .cs_n, .rst_pin_n, .wake_pin, .direct_input_0, .direct_input_1,
    .direct_input_2, .direct_input_3, .fault_detect, .sdo_oe_n, .fault_flag_n_o,
    .fault_flag_n_oe_n, .switch_outputs, .awake, .watchdog_start, .reg_wr
);

/* File: tb/qhs_host_model.sv */
// Host serial master driving the quad switch serial port
`timescale 1ns/1ps
module qhs_host_model
(
    output logic      cs_n,     // Chip select
    output logic      sclk,     // Serial clock
    output logic      sdi,      // Data to device
    input  wire logic sdo_o,    // Device out value
    input  wire logic sdo_oe_n  // Device out enable
);
    logic so_line;

    // Released line floats: inverse keeps a stale bit from matching
    assign so_line = sdo_oe_n ? ~sdo_o : sdo_o;

    initial
    begin
        cs_n = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
    end

    task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
        rx = 16'h0000;
        cs_n = 1'b0;
        #250;
        for (int i = 15; i > 15 - nbits; i--)
        begin
            // Data moves on the rise so it holds across the sampling fall
            #62.5 sclk = 1'b1;
            sdi = tx[i];
            #62.5 rx = {rx[14:0], so_line};
            sclk = 1'b0;
        end
        #100 cs_n = 1'b1;
        sdi = 1'b0;
        #1000;
    endtask

    // Clock and data wiggle while deselected; ends with clock low
    task automatic noise();
        repeat (8)
        begin
            #62.5 sclk = ~sclk;
            sdi = ~sdi;
        end
        #100;
    endtask
endmodule

/* File: tb/qhs_serial_port_test.sv */
// Self-checking bench for the quad switch serial port and pins
`timescale 1ns/1ps
module qhs_serial_port_test;
    // ------
    // Signals
    // ------
    logic        sys_clk = 1'b0;
    logic        reset = 1'b1;
    logic        rst_pin_n = 1'b0;
    logic        wake_pin = 1'b0;
    logic        pwm_mode = 1'b0;
    logic [3:0]  din = 4'h0;
    logic [3:0]  fault_detect = 4'h0;
    logic [3:0]  output_status = 4'h0;
    logic [3:0]  pwm_outputs = 4'h0;
    logic        cs_n, sclk, sdi, sdo_o, sdo_oe_n, fault_flag_n_o, fault_flag_n_oe_n;
    logic        sense_hiz, awake, watchdog_start, pwm_clk_in, reg_wr;
    logic [3:0]  switch_outputs;
    logic [2:0]  sense_sel;
    logic [4:0]  reg_addr;
    logic [9:0]  reg_data;
    logic [31:0] seed = 32'hdd168a6b;
    logic [31:0] r;
    int          mismatches = 0;
    int          check_count = 0;
    int          wr_seen = 0;

    always #2.5 sys_clk = ~sys_clk;

    always @(posedge sys_clk)
        if (reg_wr === 1'b1)
            wr_seen <= wr_seen + 1;

    qhs_serial_port dut
    (
        .sys_clk, .reset, .cs_n, .sclk, .sdi, .sdo_o, .sdo_oe_n, .rst_pin_n, .wake_pin,
        .direct_input_0(din[0]), .direct_input_1(din[1]),
        .direct_input_2(din[2]), .direct_input_3(din[3]),
        .fault_detect, .output_status, .pwm_mode, .pwm_outputs, .switch_outputs,
        .fault_flag_n_o, .fault_flag_n_oe_n, .sense_sel, .sense_hiz, .awake,
        .watchdog_start, .pwm_clk_in, .reg_wr, .reg_addr, .reg_data
    );

    qhs_host_model host
    (
        .cs_n, .sclk, .sdi, .sdo_o, .sdo_oe_n
    );

    // ------
    // Helpers
    // ------
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task report_and_stop();
        $display("Checks made %0d, mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic pin_reset();
        logic found;
        found = 1'b0;
        rst_pin_n = 1'b0;
        step(2000);
        rst_pin_n = 1'b1;
        for (int i = 0; i < 20 && !found; i++)
        begin
            step(1);
            found = (watchdog_start === 1'b1);
        end
        check("watchdog start", found, 1'b1);
        if (!found)
            report_and_stop();
        step(1000);
    endtask

    task automatic frame(input logic [4:0] addr, input logic [9:0] data, input int nbits,
                         input logic [3:0] lf);
        logic [15:0] rx;
        int          wr0;
        wr0 = wr_seen;
        host.xfer({1'b0, addr, data}, nbits, rx);
        check("write count", wr_seen - wr0, nbits == 16);
        if (nbits == 16)
        begin
            check("status", rx, {1'b0, |lf, 2'b00, lf, output_status, din});
            check("write addr", reg_addr, addr);
            check("write data", reg_data, data);
        end
    endtask

    // ------
    // Sequence
    // ------
    initial
    begin
        step(10);
        reset = 1'b0;
        step(4);
        check("so enable", sdo_oe_n, 1'b1);
        check("flag enable", fault_flag_n_oe_n, 1'b1);
        for (int k = 0; k < 5; k++)
        begin
            {wake_pin, din} = 5'h01 << k;
            step(8);
            check("awake", awake, 1'b1);
            check("direct drive", switch_outputs, din);
            {wake_pin, din} = 5'h00;
            step(8);
            check("asleep", awake, 1'b0);
        end
        pin_reset();
        check("awake", awake, 1'b1);
        for (int n = 0; n < 5; n++)
        begin
            r = (n == 0) ? 32'h0003ff00 : rnd();
            din = r[3:0];
            output_status = r[7:4];
            frame(qhs_pkg::ADDR_OUT_CTRL, r[17:8], 16, 4'h0);
            check("switches", switch_outputs, din | r[11:8]);
        end
        for (int s = 0; s < 5; s++)
        begin
            frame(qhs_pkg::ADDR_SENSE_CTRL, {6'h00, s[0], s[2:0]}, 16, 4'h0);
            check("sense select", sense_sel, s[2:0]);
            check("sense float", sense_hiz, !s[0]);
        end
        // Short frame and deselected wiggle must leave the switches alone
        frame(qhs_pkg::ADDR_OUT_CTRL, 10'h000, 8, 4'h0);
        host.noise();
        check("switches kept", switch_outputs, din | r[11:8]);
        fault_detect = 4'h5;
        step(3);
        check("flag", fault_flag_n_oe_n, 1'b0);
        check("faulted off", switch_outputs, (din | r[11:8]) & ~fault_detect);
        frame(qhs_pkg::ADDR_FAULT_CLR, 10'h000, 16, 4'h5);
        fault_detect = 4'h0;
        step(3);
        check("flag", fault_flag_n_oe_n, 1'b1);
        frame(qhs_pkg::ADDR_FAULT_CLR, 10'h000, 16, 4'h5);
        frame(qhs_pkg::ADDR_OUT_CTRL, 10'h00a, 16, 4'h0);
        check("switches", switch_outputs, din | 4'ha);
        r = rnd();
        pwm_mode = 1'b1;
        pwm_outputs = r[3:0];
        for (int p = 0; p < 6; p++)
        begin
            din[0] = ~din[0];
            step(6);
            check("pwm clock", pwm_clk_in, din[0]);
            check("pwm drive", switch_outputs, pwm_outputs);
        end
        pwm_mode = 1'b0;
        din = 4'h0;
        pin_reset();
        check("cleared switches", switch_outputs, 4'h0);
        check("cleared sense", sense_hiz, 1'b1);
        report_and_stop();
    end
endmodule
